// file: pcr2_ctrl.sv
// Control register two of the transceiver with its field decode and clock-ready timer.
//
// Overview of operation
// - Bits 1:0 pick slew rate slowest, slow, medium, fast; reset value 11.
// - Bit 2 enables automatic pair crossover; read/write, reset value 1.
// - With crossover off, bit 9 picks MDI (0) or MDIX (1); cleared by any reset.
// - Bit 6 enables detection of a partner moving from 10 to 100 Mb/s.
// - Bits 8:7 set FIFO latency 2 to 5; reset value 10.
// - Bit 11 enables automatic power saving; reset value 1.
// - MAC-side clocks are valid within 10 ms of reset release.
`timescale 1ns/10ps
module pcr2_ctrl
   import pcr2_pkg::*;
#(
   parameter int CLK_RDY_CYC = PCR2_CLK_RDY_CYC
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [4:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic sw_reset,
   input wire logic link_mdix_auto,
   output logic [15:0] reg_rdata,
   output logic reg_rdata_valid,
   output logic reserved_access,
   output logic [1:0] slew_rate_select,
   output logic auto_crossover_enable,
   output logic manual_pair_swap_select,
   output logic pair_swap_active,
   output logic partner_upshift_detect_enable,
   output logic [2:0] fifo_latency,
   output logic auto_power_saving_enable,
   output logic mac_clk_ready
);
   localparam int CW = $clog2(CLK_RDY_CYC + 1);

   // Field registers, one for each field of the register.
   logic [1:0] slew_q;
   logic [1:0] slew_d;
   logic autox_q;
   logic autox_d;
   logic [2:0] rsvd_a_q;
   logic [2:0] rsvd_a_d;
   logic upshift_q;
   logic upshift_d;
   logic [1:0] fifo_q;
   logic [1:0] fifo_d;
   logic swap_q;
   logic swap_d;
   logic rsvd_b_q;
   logic rsvd_b_d;
   logic aps_q;
   logic aps_d;
   logic [3:0] rsvd_c_q;
   logic [3:0] rsvd_c_d;

   // Read port, reserved-address flag and clock-ready timer.
   logic [15:0] rdata_q;
   logic [15:0] rdata_d;
   logic rvalid_q;
   logic rvalid_d;
   logic rsvd_q;
   logic rsvd_d;
   logic [CW-1:0] rdy_cnt_q;
   logic [CW-1:0] rdy_cnt_d;
   logic rdy_q;
   logic rdy_d;

   // Decoded access and the assembled register word.
   logic wr_hit;
   logic rd_hit;
   logic in_rsvd;
   logic [15:0] ctrl_word;

   assign wr_hit = reg_wr_en && (reg_addr == PCR2_ADDR);
   assign rd_hit = reg_rd_en && (reg_addr == PCR2_ADDR);
   // Addresses 21 to 31 are flagged and otherwise left without effect.
   assign in_rsvd = (reg_addr >= PCR2_RSVD_FIRST) && (reg_addr <= PCR2_RSVD_LAST);

   // The fields are gathered into the word that a read returns.
   always_comb begin
      ctrl_word = 16'h0000;
      ctrl_word[PCR2_SLEW_LSB +: 2] = slew_q;
      ctrl_word[PCR2_AUTOX_BIT] = autox_q;
      ctrl_word[PCR2_RSVD_A_LSB +: 3] = rsvd_a_q;
      ctrl_word[PCR2_UPSHIFT_BIT] = upshift_q;
      ctrl_word[PCR2_FIFO_LSB +: 2] = fifo_q;
      ctrl_word[PCR2_SWAP_BIT] = swap_q;
      ctrl_word[PCR2_RSVD_B_BIT] = rsvd_b_q;
      ctrl_word[PCR2_APS_BIT] = aps_q;
      ctrl_word[PCR2_RSVD_C_LSB +: 4] = rsvd_c_q;
   end

   // Reserved fields store what software writes; software keeps the defaults.
   always_comb begin
      slew_d = slew_q;
      autox_d = autox_q;
      rsvd_a_d = rsvd_a_q;
      upshift_d = upshift_q;
      fifo_d = fifo_q;
      swap_d = swap_q;
      rsvd_b_d = rsvd_b_q;
      aps_d = aps_q;
      rsvd_c_d = rsvd_c_q;
      if (wr_hit) begin
         slew_d = reg_wdata[PCR2_SLEW_LSB +: 2];
         autox_d = reg_wdata[PCR2_AUTOX_BIT];
         rsvd_a_d = reg_wdata[PCR2_RSVD_A_LSB +: 3];
         upshift_d = reg_wdata[PCR2_UPSHIFT_BIT];
         fifo_d = reg_wdata[PCR2_FIFO_LSB +: 2];
         swap_d = reg_wdata[PCR2_SWAP_BIT];
         rsvd_b_d = reg_wdata[PCR2_RSVD_B_BIT];
         aps_d = reg_wdata[PCR2_APS_BIT];
         rsvd_c_d = reg_wdata[PCR2_RSVD_C_LSB +: 4];
      end
      // A software reset in the cycle of a write still leaves bit 9 cleared.
      if (sw_reset) begin
         swap_d = PCR2_SWAP_RST;
      end
   end

   // Every field comes out of hardware reset at its own reset value.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         slew_q <= PCR2_SLEW_RST;
         autox_q <= PCR2_AUTOX_RST;
         rsvd_a_q <= PCR2_RSVD_A_RST;
         upshift_q <= PCR2_UPSHIFT_RST;
         fifo_q <= PCR2_FIFO_RST;
         swap_q <= PCR2_SWAP_RST;
         rsvd_b_q <= PCR2_RSVD_B_RST;
         aps_q <= PCR2_APS_RST;
         rsvd_c_q <= PCR2_RSVD_C_RST;
      end else begin
         slew_q <= slew_d;
         autox_q <= autox_d;
         rsvd_a_q <= rsvd_a_d;
         upshift_q <= upshift_d;
         fifo_q <= fifo_d;
         swap_q <= swap_d;
         rsvd_b_q <= rsvd_b_d;
         aps_q <= aps_d;
         rsvd_c_q <= rsvd_c_d;
      end
   end

   // A read of any other address returns zero.
   always_comb begin
      rdata_d = rdata_q;
      rvalid_d = 1'b0;
      if (reg_rd_en) begin
         rvalid_d = 1'b1;
         rdata_d = rd_hit ? ctrl_word : 16'h0000;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata_q <= 16'h0000;
         rvalid_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   // The reserved flag is a one-cycle pulse after the offending access.
   always_comb begin
      rsvd_d = (reg_rd_en || reg_wr_en) && in_rsvd;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rsvd_q <= 1'b0;
      end else begin
         rsvd_q <= rsvd_d;
      end
   end

   // The timer counts from reset release and then holds the ready level.
   always_comb begin
      rdy_cnt_d = rdy_cnt_q;
      rdy_d = rdy_q;
      if (!rdy_q) begin
         if (rdy_cnt_q == CW'(CLK_RDY_CYC - 1)) begin
            rdy_d = 1'b1;
         end else begin
            rdy_cnt_d = rdy_cnt_q + CW'(1);
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdy_cnt_q <= '0;
         rdy_q <= 1'b0;
      end else begin
         rdy_cnt_q <= rdy_cnt_d;
         rdy_q <= rdy_d;
      end
   end

   // Register read port outputs.
   assign reg_rdata = rdata_q;
   assign reg_rdata_valid = rvalid_q;
   assign reserved_access = rsvd_q;

   // Field outputs.
   assign slew_rate_select = slew_q;
   assign auto_crossover_enable = autox_q;
   assign manual_pair_swap_select = swap_q;
   // Automatic choice applies when crossover is on, the manual bit otherwise.
   assign pair_swap_active = autox_q ? link_mdix_auto : swap_q;
   assign partner_upshift_detect_enable = upshift_q;
   assign fifo_latency = 3'(PCR2_FIFO_LAT_BASE) + {1'b0, fifo_q};
   assign auto_power_saving_enable = aps_q;
   assign mac_clk_ready = rdy_q;
endmodule : pcr2_ctrl

// file: pcr2_ctrl_properties.sv
// Checker of control register two behaviour at its ports.
`timescale 1ns/10ps
module pcr2_ctrl_chk
   import pcr2_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [4:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic sw_reset,
   input wire logic link_mdix_auto,
   input wire logic reserved_access,
   input wire logic [1:0] slew_rate_select,
   input wire logic auto_crossover_enable,
   input wire logic manual_pair_swap_select,
   input wire logic pair_swap_active,
   input wire logic partner_upshift_detect_enable,
   input wire logic [2:0] fifo_latency,
   input wire logic auto_power_saving_enable,
   input wire logic mac_clk_ready
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   wire hit = reg_wr_en && reg_addr == PCR2_ADDR;
   logic [15:0] w_q;
   always_ff @(posedge clk) w_q <= reg_wdata;
   chk_slew_write: assert property (hit |=> slew_rate_select == w_q[1:0])
      else $error("slew field wrong");
   chk_autox_write: assert property (hit |=> auto_crossover_enable == w_q[2])
      else $error("crossover enable wrong");
   chk_pair_mux: assert property (pair_swap_active ==
      (auto_crossover_enable ? link_mdix_auto : manual_pair_swap_select)) else $error("pair wrong");
   chk_upshift_write: assert property (hit |=> partner_upshift_detect_enable == w_q[6])
      else $error("upshift enable wrong");
   chk_fifo_lat: assert property (hit |=> fifo_latency == {1'b0, w_q[8:7]} + 3'h2)
      else $error("latency wrong");
   chk_aps_write: assert property (hit |=> auto_power_saving_enable == w_q[11])
      else $error("power saving wrong");
   chk_rsvd_flag: assert property ((reg_wr_en || reg_rd_en) && reg_addr >= PCR2_RSVD_FIRST
      |=> reserved_access) else $error("reserved flag missing");
   chk_rsvd_quiet: assert property (!((reg_wr_en || reg_rd_en) && reg_addr >= PCR2_RSVD_FIRST)
      |=> !reserved_access) else $error("reserved flag without reserved access");
   chk_swap_clear: assert property (sw_reset |=> !manual_pair_swap_select)
      else $error("pair select not cleared");
   chk_swrst_keep: assert property (sw_reset && !hit |=> $stable(slew_rate_select)
      && $stable(auto_crossover_enable) && $stable(fifo_latency)
      && $stable(partner_upshift_detect_enable) && $stable(auto_power_saving_enable))
      else $error("software reset changed other fields");
   chk_ready_hold: assert property (mac_clk_ready |=> mac_clk_ready)
      else $error("clock ready fell");
   cover property (hit);
   cover property (sw_reset);
   cover property (reserved_access);
   cover property ($rose(mac_clk_ready));
endmodule : pcr2_ctrl_chk
bind pcr2_ctrl pcr2_ctrl_chk u_chk (
   .clk(clk),
   .nrst(nrst),
   .reg_wr_en(reg_wr_en),
   .reg_rd_en(reg_rd_en),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .sw_reset(sw_reset),
   .link_mdix_auto(link_mdix_auto),
   .reserved_access(reserved_access),
   .slew_rate_select(slew_rate_select),
   .auto_crossover_enable(auto_crossover_enable),
   .manual_pair_swap_select(manual_pair_swap_select),
   .pair_swap_active(pair_swap_active),
   .partner_upshift_detect_enable(partner_upshift_detect_enable),
   .fifo_latency(fifo_latency),
   .auto_power_saving_enable(auto_power_saving_enable),
   .mac_clk_ready(mac_clk_ready)
);

// file: pcr2_pkg.sv
// Package with the register map, field layout, reset values and timing counts of control register two.
package pcr2_pkg;
   localparam logic [4:0] PCR2_ADDR = 5'h14;
   localparam logic [4:0] PCR2_RSVD_FIRST = 5'h15;
   localparam logic [4:0] PCR2_RSVD_LAST = 5'h1F;
   localparam int PCR2_SLEW_LSB = 0;
   localparam int PCR2_AUTOX_BIT = 2;
   localparam int PCR2_RSVD_A_LSB = 3;
   localparam int PCR2_UPSHIFT_BIT = 6;
   localparam int PCR2_FIFO_LSB = 7;
   localparam int PCR2_SWAP_BIT = 9;
   localparam int PCR2_RSVD_B_BIT = 10;
   localparam int PCR2_APS_BIT = 11;
   localparam int PCR2_RSVD_C_LSB = 12;
   localparam logic [1:0] PCR2_SLEW_RST = 2'h3;
   localparam logic PCR2_AUTOX_RST = 1'b1;
   localparam logic [2:0] PCR2_RSVD_A_RST = 3'h5;
   localparam logic PCR2_UPSHIFT_RST = 1'b1;
   localparam logic [1:0] PCR2_FIFO_RST = 2'h2;
   localparam logic PCR2_SWAP_RST = 1'b0;
   localparam logic PCR2_RSVD_B_RST = 1'b1;
   localparam logic PCR2_APS_RST = 1'b1;
   localparam logic [3:0] PCR2_RSVD_C_RST = 4'h0;
   localparam logic [15:0] PCR2_RESET_VALUE = {PCR2_RSVD_C_RST, PCR2_APS_RST, PCR2_RSVD_B_RST,
      PCR2_SWAP_RST, PCR2_FIFO_RST, PCR2_UPSHIFT_RST, PCR2_RSVD_A_RST, PCR2_AUTOX_RST,
      PCR2_SLEW_RST};
   localparam int PCR2_FIFO_LAT_BASE = 2;
   localparam int PCR2_CLK_HZ = 25000000;
   localparam int PCR2_CLK_RDY_MS = 10;
   localparam int PCR2_CLK_RDY_CYC = PCR2_CLK_RDY_MS * (PCR2_CLK_HZ / 1000);
endpackage : pcr2_pkg

// file: pcr2_xover_model.sv
// Model of the crossover engine that feeds its pair choice to the block.
`timescale 1ns/10ps
module pcr2_xover_model (
   input wire logic clk,
   input wire logic nrst,
   output logic mdix
);
   logic mdix_q;
   logic mdix_d;
   always_comb mdix_d = ~mdix_q;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mdix_q <= 1'b0;
      end else begin
         mdix_q <= mdix_d;
      end
   end
   assign mdix = mdix_q;
endmodule : pcr2_xover_model

// file: tb_pcr2_ctrl.sv
// Testbench of control register two.
`timescale 1ns/10ps
module tb_pcr2_ctrl import pcr2_pkg::*; ;
   logic clk = 0, nrst = 0, wr = 0, rd = 0, swr = 0;
   logic [4:0] ad = 0;
   logic [15:0] wd = 0, v;
   wire [15:0] q;
   wire rv, ra, ax, ms, pa, up, aps, rdy, mx;
   wire [1:0] sl;
   wire [2:0] fl;
   int fail_count = 0, checks = 0;
   pcr2_xover_model u_x (.clk(clk), .nrst(nrst), .mdix(mx));
   pcr2_ctrl #(.CLK_RDY_CYC(20)) u_dut (.clk(clk), .nrst(nrst), .reg_wr_en(wr), .reg_rd_en(rd),
      .reg_addr(ad), .reg_wdata(wd), .sw_reset(swr), .link_mdix_auto(mx), .reg_rdata(q),
      .reg_rdata_valid(rv), .reserved_access(ra), .slew_rate_select(sl),
      .auto_crossover_enable(ax), .manual_pair_swap_select(ms), .pair_swap_active(pa),
      .partner_upshift_detect_enable(up), .fifo_latency(fl), .auto_power_saving_enable(aps),
      .mac_clk_ready(rdy));
   initial forever #20 clk = ~clk;
   task chk(input logic [17:0] s, input logic [17:0] e);
      checks++;
      if (s !== e) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task complete_run;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run
   task acc(input logic w, input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      #1 {wr, rd, ad, wd} = {w, !w, a, d};
      @(posedge clk);
      #1 {wr, rd} = 2'b00;
   endtask : acc
   initial begin
      repeat (4) @(posedge clk);
      #1 nrst = 1;
      chk(rdy, 0);
      acc(0, PCR2_ADDR, 0);
      chk({ra, rv, q}, {2'b01, 16'h0D6F});
      $display("reset test done");
      for (int i = 0; i < 4; i++) begin
         v = {4'h0, i[0], 2'b11, i[1:0], i[1], 3'h5, i[0], i[1:0]};
         acc(1, PCR2_ADDR, v);
         chk({aps, fl, up, ax, sl}, {i[0], 3'(i + 2), i[1], i[0], i[1:0]});
         chk(pa, i[0] ? mx : 1'b1);
         acc(0, PCR2_ADDR, 0);
         chk(q, v);
      end
      $display("field test done");
      @(posedge clk);
      #1 swr = 1;
      @(posedge clk);
      #1 swr = 0;
      v[9] = 0;
      acc(1, 5'h10, 16'h0);
      acc(0, PCR2_ADDR, 0);
      chk({ms, q}, {1'b0, v});
      $display("software reset test done");
      acc(0, PCR2_RSVD_LAST, 0);
      chk({ra, rv, q}, {2'b11, 16'h0});
      chk(rdy, 1);
      $display("reserved access test done");
      complete_run();
   end
   initial begin
      repeat (400) @(posedge clk);
      fail_count++;
      complete_run();
   end
endmodule : tb_pcr2_ctrl
